// ---- verilog/epmc_ctrl.sv ----
/*
 exception reporting and standby control of a disk target, with its
 mode page fields held in registers behind an avalon-mm slave.
 assumes one clock, command events as one-cycle pulses synchronous
 to mclk, and a command layer that acts on the check outputs.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "epmc_map.svh"

// Operation
// R1: port page reports protocol identifier one
// R2: initiator writes zero transfer timeout
// R3: idle timer and bit stored, unused
// R4: standby bit gates standby entry
// R5: standby timer counts 100 ms units
// R6: standby below sixty minutes uses sixty
// R7: logging and performance flags ignored
// R8: temperature warning needs enable, not disabled
// R9: temperature warning sense 01h/0Bh/01h
// R10: exception disable stops all exception work
// R11: test bit raises false failure 5DFFh
// R12: background functions follow enable bit
// R13: method 0 silent, 1 and 7-F unused
// R14: method 2 unit attention, command held
// R15: method 3 recovered only if post-error
// R16: method 4 recovered error always
// R17: method 5 no sense after completion
// R18: method 6 reports only on request sense
// R19: reports spaced by interval timer
// R20: zero interval reports only once
// R21: report count limits, zero unlimited
// R22: 32-bit fields, per-condition report counter
module epmc_ctrl import epmc_pkg::*; #(
	parameter int TICK_CYCLES = `EPMC_TICK_CYCLES,
	parameter int STBY_MIN_TICKS = `EPMC_STBY_MIN_TICKS
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic activity,
	input wire logic temp_over,
	input wire logic fail_predict,
	input wire logic post_error,
	input wire logic cmd_start,
	input wire logic cmd_done,
	input wire logic req_sense,
	output logic standby,
	output logic bg_enable,
	output logic cmd_block,
	output logic check_cond,
	output logic sense_valid,
	output logic [3:0] sense_key,
	output logic [7:0] additional_sense_code,
	output logic [7:0] additional_sense_qualifier
);
	epmc_bus_t bus_state;
	logic [15:0] sync_timeout;
	logic idle_bit;
	logic standby_bit;
	logic [31:0] idle_timer;
	logic [31:0] standby_timer;
	logic performance_flag;
	logic background_function_enable;
	logic warning_code_enable;
	logic exception_disable;
	logic test_bit;
	logic error_logging_flag;
	logic [3:0] method;
	logic [31:0] interval_timer;
	logic [31:0] report_count;
	logic [31:0] tick_cnt;
	logic tick;
	logic [31:0] idle_ticks;
	logic [31:0] intv_ticks;
	logic [31:0] reports;
	logic pending;
	logic [7:0] pend_asc;
	logic [7:0] pend_additional_sense_qualifier;
	logic temp_q;
	logic test_q;
	logic [31:0] next_readdata;
	logic wr_now;
	logic temp_src;
	logic test_src;
	logic new_cond;
	logic [7:0] new_asc;
	logic [7:0] new_additional_sense_qualifier;
	logic may_report;
	logic fire;
	logic [3:0] fire_key;
	logic [31:0] stby_limit;

	function automatic logic is_reg(input logic [5:0] a, input logic [5:0] ofs);
		is_reg = (a == ofs);
	endfunction

	assign wr_now = avs_write && (bus_state == EPMC_BUS_ACK);

	// avalon handshake: one wait cycle, then a single ack cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bus_state <= EPMC_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				EPMC_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state <= EPMC_BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				EPMC_BUS_ACK: begin
					bus_state <= EPMC_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state <= EPMC_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		next_readdata = 32'h0;
		if (is_reg(avs_address, `EPMC_OFS_PORT)) begin
			// R1: fixed protocol id
			next_readdata[3:0] = `EPMC_PROTO_ID;
			next_readdata[`EPMC_PORT_TMO_LSB +: 16] = sync_timeout;
		end
		if (is_reg(avs_address, `EPMC_OFS_PWR)) begin
			next_readdata[`EPMC_PWR_IDLE_BIT] = idle_bit;
			next_readdata[`EPMC_PWR_STBY_BIT] = standby_bit;
		end
		if (is_reg(avs_address, `EPMC_OFS_IDLE_TMR)) begin
			next_readdata = idle_timer;
		end
		if (is_reg(avs_address, `EPMC_OFS_STBY_TMR)) begin
			next_readdata = standby_timer;
		end
		if (is_reg(avs_address, `EPMC_OFS_EXC)) begin
			next_readdata[`EPMC_EXC_PERFORMANCE_FLAG_BIT] = performance_flag;
			next_readdata[`EPMC_EXC_EBF_BIT] = background_function_enable;
			next_readdata[`EPMC_EXC_WARNING_CODE_ENABLE_BIT] = warning_code_enable;
			next_readdata[`EPMC_EXC_EXCEPTION_DISABLE_BIT] = exception_disable;
			next_readdata[`EPMC_EXC_TEST_BIT] = test_bit;
			next_readdata[`EPMC_EXC_ERROR_LOGGING_FLAG_BIT] = error_logging_flag;
			next_readdata[`EPMC_EXC_METHOD_LSB +: 4] = method;
		end
		if (is_reg(avs_address, `EPMC_OFS_INTV)) begin
			next_readdata = interval_timer;
		end
		if (is_reg(avs_address, `EPMC_OFS_RCNT)) begin
			next_readdata = report_count;
		end
		if (is_reg(avs_address, `EPMC_OFS_STAT)) begin
			next_readdata[`EPMC_STAT_STBY_BIT] = standby;
			next_readdata[`EPMC_STAT_PEND_BIT] = pending;
			next_readdata[`EPMC_STAT_BLOCK_BIT] = cmd_block;
			next_readdata[`EPMC_STAT_RPT_LSB +: 8] = reports[7:0];
		end
	end

	// data captured with the ack, stands until the next read
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && bus_state == EPMC_BUS_IDLE) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_timeout <= 16'h0;
			idle_bit <= 1'b0;
			standby_bit <= 1'b0;
			idle_timer <= 32'h0;
			standby_timer <= 32'h0;
			interval_timer <= 32'h0;
			report_count <= 32'h0;
		end else if (wr_now) begin
			// R2: stored as written; initiator keeps it zero
			if (is_reg(avs_address, `EPMC_OFS_PORT)) begin
				sync_timeout <= avs_writedata[`EPMC_PORT_TMO_LSB +: 16];
			end
			// R3: idle values kept for readback only
			if (is_reg(avs_address, `EPMC_OFS_PWR)) begin
				idle_bit <= avs_writedata[`EPMC_PWR_IDLE_BIT];
				standby_bit <= avs_writedata[`EPMC_PWR_STBY_BIT];
			end
			if (is_reg(avs_address, `EPMC_OFS_IDLE_TMR)) begin
				idle_timer <= avs_writedata;
			end
			// R22: whole 32-bit fields
			if (is_reg(avs_address, `EPMC_OFS_STBY_TMR)) begin
				standby_timer <= avs_writedata;
			end
			if (is_reg(avs_address, `EPMC_OFS_INTV)) begin
				interval_timer <= avs_writedata;
			end
			if (is_reg(avs_address, `EPMC_OFS_RCNT)) begin
				report_count <= avs_writedata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			performance_flag <= 1'b0;
			background_function_enable <= 1'b0;
			warning_code_enable <= 1'b0;
			exception_disable <= 1'b0;
			test_bit <= 1'b0;
			error_logging_flag <= 1'b0;
			method <= 4'h0;
		end else if (wr_now && is_reg(avs_address, `EPMC_OFS_EXC)) begin
			// R7: both flags stored, only readback reads them
			performance_flag <= avs_writedata[`EPMC_EXC_PERFORMANCE_FLAG_BIT];
			error_logging_flag <= avs_writedata[`EPMC_EXC_ERROR_LOGGING_FLAG_BIT];
			background_function_enable <= avs_writedata[`EPMC_EXC_EBF_BIT];
			warning_code_enable <= avs_writedata[`EPMC_EXC_WARNING_CODE_ENABLE_BIT];
			exception_disable <= avs_writedata[`EPMC_EXC_EXCEPTION_DISABLE_BIT];
			test_bit <= avs_writedata[`EPMC_EXC_TEST_BIT];
			method <= avs_writedata[`EPMC_EXC_METHOD_LSB +: 4];
		end
	end

	// R12: background enable straight from its bit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bg_enable <= 1'b0;
		end else begin
			bg_enable <= background_function_enable;
		end
	end

	// R5: 100 ms time base
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
			tick <= 1'b0;
		end
	end

	// R6: short settings stretched to sixty minutes
	assign stby_limit = (standby_timer < 32'(STBY_MIN_TICKS)) ?
		32'(STBY_MIN_TICKS) : standby_timer;

	// R4: standby only with its bit set; activity wakes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			idle_ticks <= 32'h0;
			standby <= 1'b0;
		end else if (activity || !standby_bit) begin
			idle_ticks <= 32'h0;
			standby <= 1'b0;
		end else if (tick && !standby) begin
			if (idle_ticks + 32'h1 >= stby_limit) begin
				standby <= 1'b1;
			end
			idle_ticks <= idle_ticks + 32'h1;
		end
	end

	// R8: temperature only with enable and exceptions on
	assign temp_src = temp_over && warning_code_enable && !exception_disable;
	// R11: false failure while test bit is set
	assign test_src = test_bit && !exception_disable;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			temp_q <= 1'b0;
			test_q <= 1'b0;
		end else begin
			temp_q <= temp_src;
			test_q <= test_src;
		end
	end

	always_comb begin
		new_cond = 1'b0;
		new_asc = 8'h0;
		new_additional_sense_qualifier = 8'h0;
		// R9: temperature warning cause code
		if (temp_src && !temp_q) begin
			new_cond = 1'b1;
			new_asc = `EPMC_ASC_TEMP;
			new_additional_sense_qualifier = `EPMC_ADDITIONAL_SENSE_QUALIFIER_TEMP;
		end else if (test_src && !test_q) begin
			new_cond = 1'b1;
			new_asc = `EPMC_ASC_FAIL;
			new_additional_sense_qualifier = `EPMC_ADDITIONAL_SENSE_QUALIFIER_FALSE;
		end else if (fail_predict && !exception_disable) begin
			new_cond = 1'b1;
			new_asc = `EPMC_ASC_FAIL;
			new_additional_sense_qualifier = `EPMC_ADDITIONAL_SENSE_QUALIFIER_PRED;
		end
	end

	// R19: gap since last report must have run out
	// R20: zero interval allows the first report only
	// R21: zero count means no limit
	assign may_report = pending && (intv_ticks == 32'h0) &&
		!(interval_timer == 32'h0 && reports != 32'h0) &&
		!(report_count != 32'h0 && reports >= report_count);

	always_comb begin
		fire = 1'b0;
		fire_key = `EPMC_KEY_NO_SENSE;
		case (method)
			// R14: unit attention at command arrival
			EPMC_M_UNIT_ATTN: begin
				fire = may_report && cmd_start;
				fire_key = `EPMC_KEY_UNIT_ATTN;
			end
			// R15: gated by the post-error flag
			EPMC_M_COND_REC: begin
				fire = may_report && cmd_done && post_error;
				fire_key = `EPMC_KEY_RECOVERED;
			end
			// R16: after completion, unconditional
			EPMC_M_UNCOND_REC: begin
				fire = may_report && cmd_done;
				fire_key = `EPMC_KEY_RECOVERED;
			end
			// R17: no sense after completion
			EPMC_M_NO_SENSE: begin
				fire = may_report && cmd_done;
				fire_key = `EPMC_KEY_NO_SENSE;
			end
			// R18: only when polled
			EPMC_M_ON_REQ: begin
				fire = may_report && req_sense;
				fire_key = `EPMC_KEY_NO_SENSE;
			end
			// R13: silent for 0h, 1h and reserved codes
			default: begin
				fire = 1'b0;
				fire_key = `EPMC_KEY_NO_SENSE;
			end
		endcase
		// R10: disable overrides every method
		if (exception_disable) begin
			fire = 1'b0;
		end
	end

	// R22: a fresh condition restarts its own count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pending <= 1'b0;
			pend_asc <= 8'h0;
			pend_additional_sense_qualifier <= 8'h0;
			reports <= 32'h0;
		end else if (exception_disable) begin
			pending <= 1'b0;
			reports <= 32'h0;
		end else if (new_cond) begin
			pending <= 1'b1;
			pend_asc <= new_asc;
			pend_additional_sense_qualifier <= new_additional_sense_qualifier;
			reports <= 32'h0;
		end else begin
			if (test_q && !test_src && pend_additional_sense_qualifier == `EPMC_ADDITIONAL_SENSE_QUALIFIER_FALSE) begin
				pending <= 1'b0;
			end
			if (fire) begin
				reports <= reports + 32'h1;
			end
		end
	end

	// R19: interval restarts after each report
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			intv_ticks <= 32'h0;
		end else if (fire || new_cond) begin
			intv_ticks <= fire ? interval_timer : 32'h0;
		end else if (tick && intv_ticks != 32'h0) begin
			intv_ticks <= intv_ticks - 32'h1;
		end
	end

	// sense data held until the next report; check is a pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			check_cond <= 1'b0;
			sense_valid <= 1'b0;
			sense_key <= 4'h0;
			additional_sense_code <= 8'h0;
			additional_sense_qualifier <= 8'h0;
			cmd_block <= 1'b0;
		end else begin
			check_cond <= fire;
			// R14: the failed command is not run
			cmd_block <= fire && (method == EPMC_M_UNIT_ATTN);
			if (fire) begin
				sense_valid <= 1'b1;
				sense_key <= (pend_asc == `EPMC_ASC_TEMP) ?
					`EPMC_KEY_RECOVERED : fire_key;
				additional_sense_code <= pend_asc;
				additional_sense_qualifier <= pend_additional_sense_qualifier;
			end
		end
	end
endmodule

// ---- verilog/epmc_map.svh ----
/*
 register offsets, field positions, sense codes and timing counts
 of the exception and power mode controller; included by its bare name
*/
`ifndef EPMC_MAP_SVH
`define EPMC_MAP_SVH
`define EPMC_OFS_PORT 6'h00
`define EPMC_OFS_PWR 6'h04
`define EPMC_OFS_IDLE_TMR 6'h08
`define EPMC_OFS_STBY_TMR 6'h0C
`define EPMC_OFS_EXC 6'h10
`define EPMC_OFS_INTV 6'h14
`define EPMC_OFS_RCNT 6'h18
`define EPMC_OFS_STAT 6'h1C
`define EPMC_PROTO_ID 4'h1
`define EPMC_PORT_TMO_LSB 8
`define EPMC_PWR_IDLE_BIT 1
`define EPMC_PWR_STBY_BIT 0
`define EPMC_EXC_PERFORMANCE_FLAG_BIT 15
`define EPMC_EXC_EBF_BIT 13
`define EPMC_EXC_WARNING_CODE_ENABLE_BIT 12
`define EPMC_EXC_EXCEPTION_DISABLE_BIT 11
`define EPMC_EXC_TEST_BIT 10
`define EPMC_EXC_ERROR_LOGGING_FLAG_BIT 8
`define EPMC_EXC_METHOD_LSB 0
`define EPMC_STAT_STBY_BIT 0
`define EPMC_STAT_PEND_BIT 1
`define EPMC_STAT_BLOCK_BIT 2
`define EPMC_STAT_RPT_LSB 8
`define EPMC_KEY_NO_SENSE 4'h0
`define EPMC_KEY_RECOVERED 4'h1
`define EPMC_KEY_UNIT_ATTN 4'h6
`define EPMC_ASC_TEMP 8'h0B
`define EPMC_ADDITIONAL_SENSE_QUALIFIER_TEMP 8'h01
`define EPMC_ASC_FAIL 8'h5D
`define EPMC_ADDITIONAL_SENSE_QUALIFIER_FALSE 8'hFF
`define EPMC_ADDITIONAL_SENSE_QUALIFIER_PRED 8'h00
`define EPMC_CLK_MHZ 250
`define EPMC_TICK_MS 100
`define EPMC_TICK_CYCLES (`EPMC_TICK_MS * 1000 * `EPMC_CLK_MHZ)
`define EPMC_STBY_MIN_MIN 60
`define EPMC_STBY_MIN_TICKS (`EPMC_STBY_MIN_MIN * 60 * 1000 / `EPMC_TICK_MS)
`endif

// ---- verilog/epmc_pkg.sv ----
/*
 types of the exception and power mode controller;
 assumes epmc_map.svh for all numeric constants but the method and bus codes below
*/
package epmc_pkg;
	typedef enum logic [3:0] {
		EPMC_M_NONE = 4'h0,
		EPMC_M_ASYNC = 4'h1,
		EPMC_M_UNIT_ATTN = 4'h2,
		EPMC_M_COND_REC = 4'h3,
		EPMC_M_UNCOND_REC = 4'h4,
		EPMC_M_NO_SENSE = 4'h5,
		EPMC_M_ON_REQ = 4'h6
	} epmc_method_t;
	typedef enum logic [1:0] {
		EPMC_BUS_IDLE = 2'b01,
		EPMC_BUS_ACK = 2'b10
	} epmc_bus_t;
endpackage

// ---- tb/epmc_host.sv ----
/*
 initiator model facing epmc_ctrl: commands, request sense, activity.
 assumes it shares mclk with the design and is driven by the bench.
*/
`timescale 1ns/1ps
module epmc_host (
	input wire logic mclk,
	input wire logic cmd_block,
	output logic cmd_start,
	output logic cmd_done,
	output logic req_sense,
	output logic activity
);
	// quiet levels, called by the bench while reset is held
	task automatic init;
		cmd_start <= 1'b0;
		cmd_done <= 1'b0;
		req_sense <= 1'b0;
		activity <= 1'b0;
	endtask
	// a blocked command is dropped, never completed
	task automatic cmd(input int busy);
		logic blk;
		@(posedge mclk);
		cmd_start <= 1;
		activity <= 1;
		@(posedge mclk);
		cmd_start <= 0;
		@(posedge mclk);
		blk = cmd_block;
		repeat (busy) @(posedge mclk);
		if (blk !== 1'b1)
			cmd_done <= 1;
		@(posedge mclk);
		cmd_done <= 0;
		activity <= 0;
	endtask
	// bare activity, or request sense when rs is set
	task automatic ev(input logic rs);
		@(posedge mclk);
		req_sense <= rs;
		activity <= 1;
		@(posedge mclk);
		req_sense <= 0;
		activity <= 0;
	endtask
endmodule

// ---- tb/epmc_ctrl_assertions.sv ----
/*
 port assertions of epmc_ctrl, bound to every instance.
 assumes one clock domain and an active low reset.
*/
`timescale 1ns/1ps
module epmc_ctrl_chk #(
	parameter int TICK_CYCLES = 10,
	parameter int STBY_MIN_TICKS = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic activity,
	input wire logic cmd_start,
	input wire logic cmd_done,
	input wire logic req_sense,
	input wire logic standby,
	input wire logic cmd_block,
	input wire logic check_cond,
	input wire logic sense_valid,
	input wire logic [3:0] sense_key
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// cycles since activity was last seen
	// wide enough for the default tick and floor counts
	longint idle_cnt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			idle_cnt <= 0;
		else
			idle_cnt <= activity ? 0 : idle_cnt + 1;
	end
	a_bus_ack_due: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[1:2] !avs_waitrequest) else $error("bus ack late");
	a_bus_ack_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
	a_stby_floor: assert property ($rose(standby) |->
		idle_cnt >= longint'(STBY_MIN_TICKS - 1) * TICK_CYCLES) else $error("standby too soon");
	a_stby_wake: assert property (activity |-> ##[1:2] !standby)
		else $error("standby kept through activity");
	a_block_unit: assert property (cmd_block |-> check_cond && sense_key == 4'h6)
		else $error("block without unit attention");
	a_block_cause: assert property (cmd_block |-> $past(cmd_start))
		else $error("block without command");
	a_check_cause: assert property (check_cond |->
		$past(cmd_start || cmd_done || req_sense)) else $error("report without trigger");
	a_sense_hold: assert property (!check_cond |-> $stable(sense_key))
		else $error("sense changed without report");
	a_sense_set: assert property (check_cond |-> sense_valid)
		else $error("report without valid sense");
	c_standby: cover property ($rose(standby));
	c_block: cover property (cmd_block);
	c_recovered: cover property (check_cond && sense_key == 4'h1);
endmodule
bind epmc_ctrl epmc_ctrl_chk #(
	.TICK_CYCLES(TICK_CYCLES),
	.STBY_MIN_TICKS(STBY_MIN_TICKS)
) chk (
	.mclk(mclk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .activity(activity), .cmd_start(cmd_start),
	.cmd_done(cmd_done), .req_sense(req_sense), .standby(standby),
	.cmd_block(cmd_block), .check_cond(check_cond), .sense_valid(sense_valid),
	.sense_key(sense_key)
);

// ---- tb/epmc_ctrl_tb.sv ----
/*
 self-checking bench of epmc_ctrl over its avalon-mm slave.
 assumes epmc_host as initiator and the bound checker.
*/
`timescale 1ns/1ps
`include "epmc_map.svh"
module epmc_ctrl_tb;
	localparam int TK = 10;
	localparam int SM = 4;
	logic mclk = 0;
	logic rstn = 0;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic activity, cmd_start, cmd_done, req_sense;
	logic temp_over;
	logic fail_predict;
	logic post_error;
	logic standby, bg_enable, cmd_block, check_cond, sense_valid;
	logic [3:0] sense_key;
	logic [7:0] additional_sense_code;
	logic [7:0] additional_sense_qualifier;
	int err_count = 0;
	int checks_done = 0;
	int ncc = 0;
	int nblk = 0;
	int lim;
	logic [3:0] lkey;
	logic [15:0] lcause;
	// method table; key F means nothing reported
	logic [15:0] tx [10] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h3, 16'h8104, 16'h5, 16'h6,
		16'h7, 16'h804};
	logic [3:0] tk [10] = '{4'hF, 4'hF, 4'h6, 4'hF, 4'h1, 4'h1, 4'h0, 4'h0, 4'hF, 4'hF};
	logic [9:0] tp = 10'h010;
	int tv [2] = '{2, 6};
	epmc_ctrl #(.TICK_CYCLES(TK), .STBY_MIN_TICKS(SM)) dut (
		.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.activity(activity), .temp_over(temp_over), .fail_predict(fail_predict),
		.post_error(post_error), .cmd_start(cmd_start), .cmd_done(cmd_done),
		.req_sense(req_sense), .standby(standby), .bg_enable(bg_enable),
		.cmd_block(cmd_block), .check_cond(check_cond), .sense_valid(sense_valid),
		.sense_key(sense_key), .additional_sense_code(additional_sense_code),
		.additional_sense_qualifier(additional_sense_qualifier)
	);
	epmc_host host (
		.mclk(mclk), .cmd_block(cmd_block), .cmd_start(cmd_start),
		.cmd_done(cmd_done), .req_sense(req_sense), .activity(activity)
	);
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (check_cond === 1'b1) begin
			ncc++;
			lkey = sense_key;
			lcause = {additional_sense_code, additional_sense_qualifier};
		end
		if (cmd_block === 1'b1)
			nblk++;
	end
	task automatic cmp(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(0, a, 32'h0, q);
		cmp(q === e, "read value");
	endtask
	task automatic fp;
		@(posedge mclk);
		fail_predict <= 1;
		@(posedge mclk);
		fail_predict <= 0;
	endtask
	task automatic fin(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		$display("MISMATCH %0t watchdog", $time);
		report_and_stop();
	end
	initial begin
		avs_address <= 6'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		temp_over <= 1'b0;
		fail_predict <= 1'b0;
		post_error <= 1'b0;
		host.init();
		repeat (5) @(posedge mclk);
		rstn <= 1;
		rd(`EPMC_OFS_PORT, 32'h1);
		wr(`EPMC_OFS_PORT, 32'hE);
		rd(`EPMC_OFS_PORT, 32'h1);
		wr(`EPMC_OFS_IDLE_TMR, 32'hA5A5_5A5A);
		rd(`EPMC_OFS_IDLE_TMR, 32'hA5A5_5A5A);
		wr(`EPMC_OFS_INTV, 32'h1234_5678);
		rd(`EPMC_OFS_INTV, 32'h1234_5678);
		rd(6'h20, 32'h0);
		rd(`EPMC_OFS_STAT, 32'h0);
		wr(`EPMC_OFS_EXC, 32'h2000);
		repeat (2) @(posedge mclk);
		cmp(bg_enable === 1'b1, "background on");
		wr(`EPMC_OFS_EXC, 32'h8100);
		repeat (2) @(posedge mclk);
		cmp(bg_enable === 1'b0, "background off");
		fin("registers");
		foreach (tv[i]) begin
			wr(`EPMC_OFS_STBY_TMR, tv[i]);
			wr(`EPMC_OFS_PWR, 32'h1);
			host.ev(0);
			lim = tv[i] > SM ? tv[i] : SM;
			repeat ((lim - 1) * TK - 3) @(posedge mclk);
			cmp(standby === 1'b0, "standby early");
			repeat (TK + 8) @(posedge mclk);
			cmp(standby === 1'b1, "standby missing");
			host.ev(0);
			repeat (3) @(posedge mclk);
			cmp(standby === 1'b0, "no wake");
		end
		wr(`EPMC_OFS_PWR, 32'h2);
		host.ev(0);
		repeat (80) @(posedge mclk);
		cmp(standby === 1'b0, "standby while off");
		fin("standby");
		wr(`EPMC_OFS_INTV, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wr(`EPMC_OFS_EXC, {16'h0, tx[i]});
			post_error <= tp[i];
			fp();
			ncc = 0;
			nblk = 0;
			host.cmd(2);
			host.ev(1);
			repeat (3) @(posedge mclk);
			cmp(ncc == (tk[i] != 4'hF ? 1 : 0), "report count");
			cmp(nblk == (tk[i] == 4'h6 ? 1 : 0), "block");
			if (ncc > 0)
				cmp(lkey === tk[i] && lcause === 16'h5D00, "sense");
		end
		fin("methods");
		wr(`EPMC_OFS_EXC, 32'h4);
		temp_over <= 1;
		ncc = 0;
		host.cmd(2);
		temp_over <= 0;
		wr(`EPMC_OFS_EXC, 32'h1004);
		temp_over <= 1;
		host.cmd(2);
		host.cmd(2);
		repeat (3) @(posedge mclk);
		cmp(ncc == 1 && lkey === 4'h1 && lcause === 16'h0B01, "temperature");
		temp_over <= 0;
		fin("temperature");
		wr(`EPMC_OFS_EXC, 32'h804);
		wr(`EPMC_OFS_INTV, 32'h3);
		wr(`EPMC_OFS_EXC, 32'h404);
		ncc = 0;
		host.cmd(2);
		wr(`EPMC_OFS_EXC, 32'h4);
		repeat (40) @(posedge mclk);
		host.cmd(2);
		repeat (3) @(posedge mclk);
		cmp(ncc == 1 && lcause === 16'h5DFF, "test bit");
		for (int rc = 2; rc >= 0; rc -= 2) begin
			wr(`EPMC_OFS_RCNT, rc);
			fp();
			ncc = 0;
			host.cmd(0);
			host.cmd(0);
			repeat (3) @(posedge mclk);
			cmp(ncc == 1, "interval");
			repeat (3) begin
				repeat (40) @(posedge mclk);
				host.cmd(0);
			end
			repeat (3) @(posedge mclk);
			cmp(ncc == (rc > 0 ? 2 : 4), "report limit");
		end
		fin("interval");
		report_and_stop();
	end
endmodule
